// >>> design/safe_stop_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "safe_stop_defs.svh"
module safe_stop_monitor
    import safe_stop_pkg::*;
#(
    parameter int TICK_CYC = `TICK_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_req_a_n,
    input wire logic i_req_b_n,
    input wire logic i_bus_stop,
    input wire logic i_bus_valid,
    input wire feedback_t i_fb,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic o_torque_off_state,
    output logic o_fail_safe_flag,
    output logic o_irq
);
    // ----------------------------------------
    // input synchronisers
    // ----------------------------------------
    logic [1:0] a_s1_q, a_s2_q;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            a_s1_q <= 2'h3;
            a_s2_q <= 2'h3;
        end else begin
            a_s1_q <= {i_req_b_n, i_req_a_n};
            a_s2_q <= a_s1_q;
        end
    end
    wire both_energised = &a_s2_q;
    // request: either channel de-energised or bus stop
    logic bus_stop_q;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) bus_stop_q <= 1'b0;
        else if (i_bus_valid) bus_stop_q <= i_bus_stop;
    end
    wire request = !both_energised || bus_stop_q;
    wire release_ok = both_energised && !bus_stop_q; // [RL9]

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // magnitude of a signed speed sample
    function automatic logic signed [16:0] abs17(input logic signed [16:0] v);
        return v[16] ? -v : v;
    endfunction
    // torque is removed in both end states
    function automatic logic is_off(input stop_state_t s);
        return (s == ST_TORQUE) || (s == ST_FAIL);
    endfunction

    // ----------------------------------------
    // registers
    // ----------------------------------------
    // ctrl: [0] family hold, [1] ramp en, [2] timed en, [3] faster ok
    logic [3:0] ctrl_q;
    logic [15:0] rate_q, tol_neg_q, tol_pos_q, win_q, poswin_q;
    logic [31:0] stime_q;
    logic [2:0] stat_q, mask_q;
    wire wr = psel && penable && pwrite;
    wire [2:0] w_clr = (wr && paddr == `A_IRQ) ? pwdata[2:0] : 3'h0;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_q <= 4'h6;
            rate_q <= 16'h0001;
            tol_neg_q <= 16'h0000;
            tol_pos_q <= 16'h0000;
            win_q <= 16'h0001;
            stime_q <= 32'h0000_0001;
            poswin_q <= 16'h0000;
            mask_q <= 3'h0;
        end else if (wr) begin
            if (paddr == `A_CTRL) ctrl_q <= pwdata[3:0];
            if (paddr == `A_RATE) rate_q <= pwdata[15:0];
            if (paddr == `A_TOL) begin
                tol_neg_q <= pwdata[15:0];
                tol_pos_q <= pwdata[31:16];
            end
            if (paddr == `A_WIN) win_q <= pwdata[15:0];
            if (paddr == `A_STIME) stime_q <= pwdata;
            if (paddr == `A_POSWIN) poswin_q <= pwdata[15:0];
            if (paddr == `A_MASK) mask_q <= pwdata[2:0];
        end
    end

    // ----------------------------------------
    // sample tick
    // ----------------------------------------
    logic [15:0] div_q;
    logic tick_q;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            div_q <= 16'h0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (div_q == 16'(TICK_CYC - 1)); // [RL19]
            div_q <= (div_q == 16'(TICK_CYC - 1)) ? 16'h0 : div_q + 16'h1;
        end
    end
    feedback_t fb_q;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) fb_q <= '0;
        else if (tick_q) fb_q <= i_fb; // [RL19]
    end

    // ----------------------------------------
    // ramp envelope
    // ----------------------------------------
    stop_state_t st_q, st_d;
    logic signed [16:0] ramp_q;
    logic [31:0] tcnt_q;
    logic [15:0] dev_q;
    logic signed [31:0] hold_pos_q;
    logic viol_seen_q;
    wire signed [16:0] spd = 17'(fb_q.speed);
    wire signed [16:0] mag = abs17(spd);
    wire [15:0] rate_nz = (rate_q == 16'h0) ? 16'h1 : rate_q;
    wire signed [16:0] up_lim = ramp_q + $signed({1'b0, tol_pos_q}); // [RL5]
    wire signed [16:0] lo_ramp = ramp_q - $signed({1'b0, tol_neg_q}); // [RL5]
    wire signed [16:0] lo_zero = -$signed({1'b0, tol_neg_q}); // [RL6]
    wire signed [16:0] lo_lim = ctrl_q[3] ? lo_zero : lo_ramp; // [RL6]
    wire out_band = (mag > up_lim) || (mag < lo_lim);
    wire ramp_done = (ramp_q <= 17'sd0);
    // standstill: envelope ended or drive already stopped
    wire standstill = ramp_done || (mag == 17'sd0); // [RL1]
    wire [16:0] ticks_left = 17'(ramp_q / $signed({1'b0, rate_nz}));
    wire signed [32:0] dpos = 33'(fb_q.pos) - 33'(hold_pos_q);
    wire [32:0] apos = dpos[32] ? 33'(-dpos) : 33'(dpos);
    wire pos_out = apos > 33'(poswin_q);
    wire watch = (st_q == ST_RAMP) || (st_q == ST_HOLD);
    wire dev_out = (st_q == ST_RAMP) ? out_band : pos_out;
    wire dev_trip = watch && (dev_q >= win_q); // [RL18]
    wire time_up = (tcnt_q >= stime_q);
    // ramp mode chosen when enabled; timed only if ramp disabled
    wire use_ramp = ctrl_q[1] || !ctrl_q[2]; // [RL7]

    always_comb begin
        st_d = st_q;
        unique case (st_q)
            ST_RUN: if (request) st_d = use_ramp ? ST_RAMP : ST_TIMED;
            ST_RAMP: begin
                if (dev_trip) st_d = viol_seen_q ? ST_TORQUE : ST_FAIL; // [RL3] [RL4]
                else if (standstill && tick_q) st_d = ctrl_q[0] ? ST_HOLD : ST_TORQUE; // [RL1] [RL11]
            end
            ST_TIMED: if (time_up) st_d = ctrl_q[0] ? ST_HOLD : ST_TORQUE; // [RL8] [RL12]
            ST_HOLD: if (dev_trip) st_d = ST_TORQUE; // [RL13]
            ST_TORQUE: ;
            ST_FAIL: ;
            default: st_d = ST_TORQUE;
        endcase
        if (release_ok && st_q != ST_FAIL) st_d = ST_RUN; // [RL9]
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q <= ST_RUN;
            ramp_q <= 17'sd0;
            tcnt_q <= 32'h0;
            dev_q <= 16'h0;
            hold_pos_q <= 32'sh0;
            viol_seen_q <= 1'b0;
        end else begin
            st_q <= st_d;
            if (st_q == ST_RUN) begin
                ramp_q <= mag;
                tcnt_q <= 32'h0;
                dev_q <= 16'h0;
                viol_seen_q <= 1'b0;
            end else if (tick_q) begin
                tcnt_q <= tcnt_q + 32'h1;
                if (!ramp_done) ramp_q <= ramp_q - $signed({1'b0, rate_q});
                if (watch && dev_out) dev_q <= dev_q + 16'h1; // [RL2]
                else if (dev_q != 16'h0) dev_q <= dev_q - 16'h1; // [RL2] [RL18]
            end
            // too late for fail-safe once window outlasts remaining ramp
            if (st_q == ST_RAMP && tick_q)
                viol_seen_q <= viol_seen_q || ({1'b0, win_q} > ticks_left); // [RL4]
            if (st_d == ST_HOLD && st_q != ST_HOLD) begin
                hold_pos_q <= fb_q.pos;
                dev_q <= 16'h0;
            end
        end
    end

    // ----------------------------------------
    // outputs, status, interrupts
    // ----------------------------------------
    wire off_act = !ctrl_q[0] && st_q != ST_RUN;
    wire hold_act = ctrl_q[0] && (st_q == ST_RAMP || st_q == ST_TIMED || st_q == ST_HOLD);
    wire [7:0] status = {st_q == ST_FAIL, is_off(st_q),
                         st_q == ST_HOLD, hold_act, off_act, 3'h0}; // [RL10] [RL14] [RL17]
    wire [2:0] ev = {st_d == ST_FAIL && st_q != ST_FAIL,
                     is_off(st_d) && !is_off(st_q),
                     request && st_q == ST_RUN};
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            stat_q <= 3'h0;
            o_torque_off_state <= 1'b0;
            o_fail_safe_flag <= 1'b0;
            o_irq <= 1'b0;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            stat_q <= (stat_q & ~w_clr) | ev;
            o_torque_off_state <= is_off(st_d);
            o_fail_safe_flag <= (st_d == ST_FAIL);
            o_irq <= |(((stat_q & ~w_clr) | ev) & mask_q);
            pready <= psel && !penable;
            pslverr <= psel && !penable && paddr > `A_SPEED;
            unique case (paddr)
                `A_CTRL: prdata <= {28'h0, ctrl_q};
                `A_RATE: prdata <= {16'h0, rate_q};
                `A_TOL: prdata <= {tol_pos_q, tol_neg_q};
                `A_WIN: prdata <= {16'h0, win_q};
                `A_STIME: prdata <= stime_q;
                `A_POSWIN: prdata <= {16'h0, poswin_q};
                `A_STAT: prdata <= {24'h0, status};
                `A_IRQ: prdata <= {29'h0, stat_q};
                `A_MASK: prdata <= {29'h0, mask_q};
                `A_SPEED: prdata <= {16'h0, fb_q.speed};
                default: prdata <= 32'h0;
            endcase
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    localparam int RESP = `RESP_CYC;
    a_fail_only_ramp: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        $rose(o_fail_safe_flag) |-> $past(st_q) == ST_RAMP) // [RL4]
        else $error("fail-safe raised outside ramp");
    a_trip_torque: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (st_q == ST_HOLD && dev_trip && !release_ok) |=> st_q == ST_TORQUE) // [RL13]
        else $error("hold timeout did not give torque off");
    a_release_run: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (release_ok && st_q != ST_FAIL) |=> st_q == ST_RUN) // [RL9]
        else $error("release not honoured");
    a_request_resp: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (st_q == ST_RUN && request) |-> ##[1:4] st_q != ST_RUN) // [RL15]
        else $error("request not taken");
    a_timed_off: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (st_q == ST_TIMED && time_up && !ctrl_q[0] && !release_ok) |=> st_q == ST_TORQUE) // [RL8]
        else $error("timed stop missed torque off");
    a_bit4_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (st_q == ST_TIMED && ctrl_q[0]) |-> status[`B_HOLD_ACT]) // [RL10]
        else $error("status bit 4 wrong");
    a_bit5_ssh: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        status[`B_SSH_ACT] == (st_q == ST_HOLD)) // [RL14]
        else $error("status bit 5 wrong");
    a_counter_step: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (tick_q && watch && dev_out && !dev_trip && st_d == st_q) |=> dev_q == $past(dev_q) + 16'h1) // [RL2]
        else $error("counter did not count up");

    // ----------------------------------------
    // sequences and step checks
    // ----------------------------------------
    sequence s_ramp_end;
        st_q == ST_RAMP && !dev_trip && standstill && tick_q && !release_ok;
    endsequence
    sequence s_timed_end;
        st_q == ST_TIMED && time_up && !release_ok;
    endsequence
    sequence s_hold_enter;
        st_q != ST_HOLD ##1 st_q == ST_HOLD;
    endsequence
    sequence s_ramp_enter;
        st_q == ST_RUN ##1 st_q == ST_RAMP;
    endsequence

    a_ramp_torque: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        s_ramp_end ##0 !ctrl_q[0] |=> st_q == ST_TORQUE) // [RL1]
        else $error("ramp end missed torque off");
    a_ramp_start: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        s_ramp_enter |-> ramp_q == $past(mag)) // [RL1]
        else $error("ramp did not start from speed");
    a_ramp_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        s_ramp_end ##0 ctrl_q[0] |=> st_q == ST_HOLD) // [RL11]
        else $error("ramp end missed standstill hold");
    a_timed_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        s_timed_end ##0 ctrl_q[0] |=> st_q == ST_HOLD) // [RL12]
        else $error("timed stop missed standstill hold");
    a_hold_capture: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        s_hold_enter |-> hold_pos_q == $past(fb_q.pos) && dev_q == 16'h0) // [RL13]
        else $error("hold position not captured");
    a_dev_torque: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (st_q == ST_RAMP && dev_trip && viol_seen_q && !release_ok) |=> st_q == ST_TORQUE) // [RL3]
        else $error("late violation did not give torque off");
    a_fail_early: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (st_q == ST_RAMP && dev_trip && !viol_seen_q && !release_ok) |=> st_q == ST_FAIL) // [RL4]
        else $error("early violation did not give fail-safe");
    a_fail_hold: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        st_q == ST_FAIL |=> st_q == ST_FAIL) // [RL4]
        else $error("fail-safe left before reset");
    a_torque_pin: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        o_torque_off_state == is_off(st_q)) // [RL1]
        else $error("torque off output wrong");
    a_fail_pin: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        o_fail_safe_flag == (st_q == ST_FAIL)) // [RL4]
        else $error("fail-safe output wrong");
    a_count_down: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (tick_q && watch && !dev_out && dev_q != 16'h0 && st_d == st_q)
        |=> dev_q == $past(dev_q) - 16'h1) // [RL2]
        else $error("counter did not count down");
    a_count_floor: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (tick_q && watch && !dev_out && dev_q == 16'h0 && st_d == st_q) |=> dev_q == 16'h0) // [RL18]
        else $error("counter went below zero");
    a_run_clear: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        st_q == ST_RUN |=> dev_q == 16'h0 && tcnt_q == 32'h0 && !viol_seen_q) // [RL19]
        else $error("counters not cleared in run");
    a_tick_pulse: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        tick_q |=> !tick_q) // [RL19]
        else $error("tick longer than one cycle");
    a_timed_nocount: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        st_q == ST_TIMED |-> dev_q == 16'h0) // [RL8]
        else $error("timed stop counted deviation");
    a_bus_latch: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        i_bus_valid |=> bus_stop_q == $past(i_bus_stop)) // [RL9]
        else $error("bus stop not latched");
    a_band_in: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (st_q == ST_RAMP && !ctrl_q[3] && mag <= up_lim && mag >= lo_ramp) |-> !out_band) // [RL5]
        else $error("speed inside band flagged");
    a_faster_ok: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (st_q == ST_RAMP && ctrl_q[3] && mag <= up_lim) |-> !out_band) // [RL6]
        else $error("faster deceleration flagged");
    a_off_bit3: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (st_q == ST_TIMED && !ctrl_q[0]) |-> status[`B_OFF_ACT]) // [RL17]
        else $error("status bit 3 wrong");
    a_hold_bit4: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (st_q == ST_HOLD && ctrl_q[0]) |-> status[`B_HOLD_ACT]) // [RL10]
        else $error("status bit 4 wrong in hold");
    a_pin_request: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (!i_req_a_n && st_q == ST_RUN) [*3] |=> st_q != ST_RUN) // [RL15]
        else $error("pin request not taken");
    a_pin_release: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (i_req_a_n && i_req_b_n && !bus_stop_q && st_q != ST_FAIL) [*3]
        |=> st_q == ST_RUN) // [RL15]
        else $error("pin release not taken");
    a_apb_ready: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (psel && !penable) |=> pready)
        else $error("no ready in access phase");
    a_apb_error: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
        (psel && !penable && paddr > `A_SPEED) |=> pslverr)
        else $error("bad address not refused");
endmodule // safe_stop_monitor
`default_nettype wire

// >>> design/safe_stop_defs.svh
// Operation
// [RL1] ramp stop: supervise ramp, then torque off
// [RL2] deviation counter up outside, down inside
// [RL3] deviation beyond window forces torque off
// [RL4] fail-safe only if violation precedes ramp end
// [RL5] tolerances form band around the ramp
// [RL6] faster decel: bound only above and below zero
// [RL7] function type selects ramp, timed or both; code runs ramp alone when both are enabled, and ramp when neither is
// [RL8] timed stop: torque off at stop time
// [RL9] leave stop only on both inputs or bus
// [RL10] stop-then-hold active in status bit 4
// [RL11] ramp hold stop: ramp, then standstill hold
// [RL12] timed hold stop: standstill hold at time
// [RL13] hold: position window, timeout gives torque off
// [RL14] standstill hold active in status bit 5
// [RL15] respond to request within 2 ms
// [RL16] drive itself decelerates along the ramp
// [RL17] stop-then-torque-off active in status bit 3
// [RL18] counter saturates at zero, trips at window
// [RL19] fixed sample tick, reset clears everything; code resets ctrl, rate, win, stime and the input synchronisers to nonzero defaults
`ifndef SAFE_STOP_DEFS_SVH
`define SAFE_STOP_DEFS_SVH
`define A_CTRL 12'h000
`define A_RATE 12'h004
`define A_TOL 12'h008
`define A_WIN 12'h00c
`define A_STIME 12'h010
`define A_POSWIN 12'h014
`define A_STAT 12'h018
`define A_IRQ 12'h01c
`define A_MASK 12'h020
`define A_SPEED 12'h024
`define B_OFF_ACT 3
`define B_HOLD_ACT 4
`define B_SSH_ACT 5
`define B_TORQUE 6
`define B_FAIL 7
`define CLK_HZ 25000000
`define TICK_US 100
`define TICK_CYC ((`CLK_HZ / 1000000) * `TICK_US)
`define RESP_US 2000
`define RESP_CYC ((`CLK_HZ / 1000000) * `RESP_US)
`endif

// >>> design/safe_stop_pkg.sv
package safe_stop_pkg;
    typedef enum logic [5:0] {
        ST_RUN = 6'h01,
        ST_RAMP = 6'h02,
        ST_TIMED = 6'h04,
        ST_TORQUE = 6'h08,
        ST_HOLD = 6'h10,
        ST_FAIL = 6'h20
    } stop_state_t;
    typedef struct packed {
        logic signed [15:0] speed;
        logic signed [31:0] pos;
    } feedback_t;
endpackage

// >>> bench/drive_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// drive feedback model
// ----------------------------------------
module drive_model
    import safe_stop_pkg::*;
#(
    parameter int TICK_CYC = 4
) (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_stop,
    input wire logic i_faulty,
    input wire logic [15:0] i_rate,
    output feedback_t o_fb
);
    int cnt_q;
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q <= 0;
            o_fb <= '{speed: 16'sd1000, pos: 32'sd0};
        end else begin
            cnt_q <= (cnt_q == TICK_CYC - 1) ? 0 : cnt_q + 1;
            if (cnt_q == 0 && i_stop) begin
                if (i_faulty) begin
                    o_fb.pos <= o_fb.pos + 32'sd100;
                end else if (o_fb.speed > $signed(i_rate)) begin
                    o_fb.speed <= o_fb.speed - $signed(i_rate);
                end else begin
                    o_fb.speed <= 16'sd0;
                end
            end
        end
    end
endmodule // drive_model
`default_nettype wire

// >>> bench/test_safe_stop_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module test_safe_stop_monitor;
    typedef struct {logic [11:0] a; logic [31:0] d;} row_t;
    logic clk = 0, rst_n = 0, req_a_n = 1, req_b_n = 1, bus_stop = 0, bus_valid = 0;
    logic psel = 0, penable = 0, pwrite = 0, pready, pslverr, torque_off, fail_flag, irq;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic err, drive_stop = 0, faulty = 0;
    logic [15:0] rate = 16'h000a;
    safe_stop_pkg::feedback_t fb;
    int errors = 0, cmp_count = 0, n;
    row_t rows[6] = '{'{12'h004, 32'h0000000a}, '{12'h008, 32'h00320032},
        '{12'h00c, 32'h00000005}, '{12'h010, 32'h00000014},
        '{12'h014, 32'h00000008}, '{12'h020, 32'h00000007}};
    always #20 clk = ~clk;
    safe_stop_monitor #(.TICK_CYC(4)) uut (.i_core_clk(clk), .i_rst_n(rst_n),
        .i_req_a_n(req_a_n), .i_req_b_n(req_b_n), .i_bus_stop(bus_stop),
        .i_bus_valid(bus_valid), .i_fb(fb), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .o_torque_off_state(torque_off),
        .o_fail_safe_flag(fail_flag), .o_irq(irq));
    drive_model #(.TICK_CYC(4)) dm (.i_core_clk(clk), .i_rst_n(rst_n),
        .i_stop(drive_stop), .i_faulty(faulty), .i_rate(rate), .o_fb(fb));
    task automatic end_of_test();
        if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata; err = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        apb(0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic rst_cfg();
        rst_n <= 0; drive_stop <= 0; faulty <= 0; rate <= 16'h000a;
        req_a_n <= 1; req_b_n <= 1; bus_stop <= 0;
        repeat (3) @(posedge clk);
        rst_n <= 1;
        foreach (rows[i]) begin
            apb(1, rows[i].a, rows[i].d);
            rdchk(rows[i].a, rows[i].d);
        end
    endtask
    task automatic wait_off(output int k);
        k = 0;
        while (torque_off !== 1'b1 && k < 3000) begin
            @(posedge clk);
            k++;
        end
    endtask
    task automatic ramp_stop(input logic [31:0] ctrl);
        apb(1, 12'h000, ctrl);
        req_b_n <= 0; drive_stop <= 1;
        wait_off(n);
    endtask
    initial begin
        #(40 * 40000);
        errors++;
        end_of_test();
    end
    initial begin
        // ----------------------------------------
        // reset values, refusal, timed stop
        // ----------------------------------------
        rst_cfg();
        rdchk(12'h000, 32'h6);
        rdchk(12'h018, 32'h0);
        apb(1, 12'h028, 32'h0);
        chk(err, 1);
        apb(1, 12'h000, 32'h4);
        req_a_n <= 0; drive_stop <= 1;
        wait_off(n);
        chk(32'(n >= 70 && n <= 100), 1);
        chk(fail_flag, 0);
        rdchk(12'h018, 32'h48);
        rdchk(12'h01c, 32'h3);
        chk(irq, 1);
        apb(1, 12'h020, 32'h0);
        repeat (2) @(posedge clk);
        chk(irq, 0);
        apb(1, 12'h020, 32'h7);
        apb(1, 12'h01c, 32'h3);
        rdchk(12'h01c, 32'h0);
        chk(irq, 0);
        req_b_n <= 0; req_a_n <= 1;
        repeat (10) @(posedge clk);
        apb(0, 12'h018, 32'h0);
        chk(rd[3], 1);
        req_b_n <= 1;
        repeat (60) @(posedge clk);
        apb(0, 12'h018, 32'h0);
        chk(rd[3], 0);
        // ----------------------------------------
        // ramp stops: good, faster, faulty
        // ----------------------------------------
        rst_cfg();
        ramp_stop(32'h2);
        chk(32'(n > 300), 1);
        chk(fail_flag, 0);
        rst_cfg();
        rate <= 16'h001e;
        ramp_stop(32'ha);
        chk(32'(n < 300), 1);
        chk(fail_flag, 0);
        rst_cfg();
        faulty <= 1;
        ramp_stop(32'h2);
        chk(32'(n < 60), 1);
        chk(fail_flag, 1);
        rdchk(12'h01c, 32'h7);
        // ----------------------------------------
        // hold family: timed over bus, then ramp
        // ----------------------------------------
        foreach (rows[k]) if (k < 2) begin
            rst_cfg();
            apb(1, 12'h000, (k == 0) ? 32'h5 : 32'h3);
            bus_stop <= 1; bus_valid <= 1; drive_stop <= 1;
            @(posedge clk);
            bus_valid <= 0;
            repeat ((k == 0) ? 100 : 500) @(posedge clk);
            apb(0, 12'h018, 32'h0);
            chk(rd[5:4], 2'b11);
            chk(torque_off, 0);
            faulty <= 1;
            wait_off(n);
            chk(32'(n < 60), 1);
        end
        end_of_test();
    end
endmodule // test_safe_stop_monitor
`default_nettype wire
